// [common/aux_ram_defs.vh]
// Purpose: constants for the auxiliary data RAM and its access decoder
// Assumes: 8-bit special-register bus, 125 MHz core clock
// Notes: included by the decoder only
//
// Overview of operation
// - 1024 bytes on-chip, addresses 000H to 3FFH
// - Enable bit set after every reset
// - Reached only by external moves, two modes
// - Enabled: indirect moves always hit aux RAM
// - Data pointer above 03FFH always off-chip
// - Disabled: low addresses go off-chip
// - Chip control writes need timed access unlock
// - No pin activity during on-chip access
// - Stack never addresses the aux RAM
// - Bit 4 of chip control enables RAM
// - Page bits 1:0 give address 9:8
// - Off-chip accesses use the multiplexed ports
`ifndef AUX_RAM_DEFS_VH
`define AUX_RAM_DEFS_VH

// =====================================================================
// Register map
`define CHIP_CONTROL_ADDR 8'h9F
`define AUX_RAM_PAGE_HIGH_ADDR 8'hA1
`define CHIP_CONTROL_RESET 8'h10
`define CHIP_CONTROL_RW_MASK 8'h73
`define AUX_RAM_PAGE_HIGH_RESET 2'h0
`define AUX_RAM_ENABLE_BIT 4

// =====================================================================
// Aux RAM geometry
`define AUX_RAM_DEPTH 1024
`define AUX_RAM_AW 10
`define AUX_RAM_TOP 16'h03FF

// =====================================================================
// Off-chip strobe timing
`define STROBE_NS 32
`define STROBE_CYCLES ((`STROBE_NS + 7) / 8)
`define STROBE_CNT_W 3

`endif

// [logic/aux_ram_access_decoder.v]
// Purpose: 1 KB auxiliary data RAM and external-move address decode
// Assumes: core drives requests synchronously on clock; pins async
// Notes: one external move in flight at a time; busy requests dropped
`timescale 1ns/100ps
`include "aux_ram_defs.vh"

module aux_ram_access_decoder (
  input wire clock,
  input wire rst,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire timed_access_open,
  output reg [7:0] sfr_rdata,
  input wire xm_req,
  input wire xm_write,
  input wire xm_use_data_pointer,
  input wire [15:0] data_pointer,
  input wire [7:0] indirect_reg,
  input wire [7:0] xm_wdata,
  output reg xm_done,
  output reg [7:0] xm_rdata,
  output reg xm_offchip,
  output reg xm_busy,
  output reg aux_ram_enable,
  output reg [7:0] low_addr_data_port_out,
  output reg low_addr_data_port_oe,
  input wire [7:0] low_addr_data_port_in,
  output reg [7:0] high_addr_port_out,
  output reg high_addr_port_oe,
  output reg addr_latch_en,
  output reg ext_wr_n,
  output reg ext_rd_n
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ADDR = 2'b01;
  localparam [1:0] ST_STROBE = 2'b10;

  // ===================================================================
  // Storage and state
  reg [7:0] aux_data_ram [0:`AUX_RAM_DEPTH-1];
  // Stored bits that software reads back beside the enable
  reg [7:0] chip_control_rest;
  reg [1:0] aux_ram_page_high;
  reg [1:0] state;
  reg [`STROBE_CNT_W-1:0] strobe_cnt;
  reg cyc_write;
  reg [7:0] cyc_wdata;
  reg [7:0] pin_meta;
  reg [7:0] pin_sync;
  wire [15:0] req_addr;
  wire req_on_chip;
  wire [7:0] chip_control_view;
  wire cc_write;
  wire cc_read;
  wire page_write;
  wire page_read;
  wire [31:0] strobe_full;
  wire [`STROBE_CNT_W-1:0] strobe_load;

  // ===================================================================
  // Decode helpers
  function [15:0] move_address;
    input use_dp;
    input [15:0] dp;
    input [7:0] ri;
    input [1:0] page;
    begin
      if (use_dp)
      begin
        move_address = dp;
      end
      else
      begin
        move_address = {6'h00, page, ri};
      end
    end
  endfunction

  function on_chip_hit;
    input use_dp;
    input [15:0] dp;
    input en;
    begin
      if (!en)
      begin
        on_chip_hit = 1'b0;
      end
      else if (use_dp)
      begin
        on_chip_hit = (dp <= `AUX_RAM_TOP);
      end
      else
      begin
        on_chip_hit = 1'b1;
      end
    end
  endfunction

  // Shared by the read and write decode of both registers
  function reg_sel;
    input [7:0] addr;
    input [7:0] target;
    begin
      reg_sel = (addr == target);
    end
  endfunction

  assign req_addr = move_address(xm_use_data_pointer, data_pointer,
                                 indirect_reg, aux_ram_page_high);
  assign req_on_chip = on_chip_hit(xm_use_data_pointer, data_pointer,
                                   aux_ram_enable);
  assign chip_control_view = (chip_control_rest & `CHIP_CONTROL_RW_MASK)
    | ({7'h00, aux_ram_enable} << `AUX_RAM_ENABLE_BIT);
  assign cc_write = sfr_wr & reg_sel(sfr_addr, `CHIP_CONTROL_ADDR);
  assign cc_read = sfr_rd & reg_sel(sfr_addr, `CHIP_CONTROL_ADDR);
  assign page_write = sfr_wr & reg_sel(sfr_addr, `AUX_RAM_PAGE_HIGH_ADDR);
  assign page_read = sfr_rd & reg_sel(sfr_addr, `AUX_RAM_PAGE_HIGH_ADDR);
  // Count is loaded with cycles minus one; only the low bits are kept
  assign strobe_full = `STROBE_CYCLES - 1;
  assign strobe_load = strobe_full[`STROBE_CNT_W-1:0];

  // ===================================================================
  // Special-register access
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      aux_ram_enable <= 1'b1;
      chip_control_rest <= 8'h00;
      aux_ram_page_high <= `AUX_RAM_PAGE_HIGH_RESET;
      sfr_rdata <= 8'h00;
    end
    else
    begin
      if (cc_write && timed_access_open)
      begin
        aux_ram_enable <= sfr_wdata[`AUX_RAM_ENABLE_BIT];
        chip_control_rest <= sfr_wdata & `CHIP_CONTROL_RW_MASK;
      end
      if (page_write)
      begin
        aux_ram_page_high <= sfr_wdata[1:0];
      end
      if (cc_read)
      begin
        sfr_rdata <= chip_control_view;
      end
      else if (page_read)
      begin
        sfr_rdata <= {6'h00, aux_ram_page_high};
      end
      else
      begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // ===================================================================
  // Pin input synchroniser
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end
    else
    begin
      pin_meta <= low_addr_data_port_in;
      // Only this stage feeds logic; pin_meta may be metastable
      pin_sync <= pin_meta;
    end
  end

  // ===================================================================
  // Aux RAM array; no reset so it maps to plain storage
  // only external moves reach here
  // no stack path into the array
  always @(posedge clock)
  begin
    // on-chip write hit (pointer or indirect) writes RAM; reads are done in the sequencer
    if (state == ST_IDLE && xm_req && req_on_chip && xm_write)
    begin
      aux_data_ram[req_addr[`AUX_RAM_AW-1:0]] <= xm_wdata;
    end
  end

  // ===================================================================
  // External move sequencer
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      strobe_cnt <= {`STROBE_CNT_W{1'b0}};
      cyc_write <= 1'b0;
      cyc_wdata <= 8'h00;
      xm_done <= 1'b0;
      xm_rdata <= 8'h00;
      xm_offchip <= 1'b0;
      xm_busy <= 1'b0;
      low_addr_data_port_out <= 8'h00;
      low_addr_data_port_oe <= 1'b0;
      high_addr_port_out <= 8'h00;
      high_addr_port_oe <= 1'b0;
      addr_latch_en <= 1'b0;
      ext_wr_n <= 1'b1;
      ext_rd_n <= 1'b1;
    end
    else
    begin
      xm_done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (xm_req && req_on_chip)
          begin
            xm_offchip <= 1'b0;
            xm_done <= 1'b1;
            if (!xm_write)
            begin
              xm_rdata <= aux_data_ram[req_addr[`AUX_RAM_AW-1:0]];
            end
          end
          else if (xm_req)
          begin
            xm_offchip <= 1'b1;
            // Requests are dropped until this cycle ends
            xm_busy <= 1'b1;
            cyc_write <= xm_write;
            cyc_wdata <= xm_wdata;
            high_addr_port_out <= req_addr[15:8];
            high_addr_port_oe <= 1'b1;
            low_addr_data_port_out <= req_addr[7:0];
            low_addr_data_port_oe <= 1'b1;
            addr_latch_en <= 1'b1;
            state <= ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          addr_latch_en <= 1'b0;
          strobe_cnt <= strobe_load;
          if (cyc_write)
          begin
            low_addr_data_port_out <= cyc_wdata;
            ext_wr_n <= 1'b0;
          end
          else
          begin
            low_addr_data_port_oe <= 1'b0;
            ext_rd_n <= 1'b0;
          end
          state <= ST_STROBE;
        end
        ST_STROBE:
        begin
          if (strobe_cnt == {`STROBE_CNT_W{1'b0}})
          begin
            if (!cyc_write)
            begin
              // Pin value is two cycles old; strobe outlasts the lag
              xm_rdata <= pin_sync;
            end
            ext_wr_n <= 1'b1;
            ext_rd_n <= 1'b1;
            low_addr_data_port_oe <= 1'b0;
            high_addr_port_oe <= 1'b0;
            xm_busy <= 1'b0;
            xm_done <= 1'b1;
            state <= ST_IDLE;
          end
          else
          begin
            strobe_cnt <= strobe_cnt - 1'b1;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // aux_ram_access_decoder

// [tb/aux_ram_access_decoder_tb_top.sv]
// Purpose: self-checking bench for the aux RAM decoder
// Assumes: off-chip memory model on the ports
// Notes: expected results queued, a watcher compares
`timescale 1ns/100ps
module aux_ram_access_decoder_tb_top;
  reg clock = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, timed_access_open = 0;
  reg xm_req = 0, xm_write = 0, xm_use_data_pointer = 0, rd_pend = 0;
  reg [7:0] sfr_addr = 0, sfr_wdata = 0, indirect_reg = 0, xm_wdata = 0, d;
  reg [15:0] data_pointer = 0, p;
  reg [9:0] a, e;
  reg [7:0] sq[$];
  reg [9:0] xq[$];
  wire [7:0] sfr_rdata, xm_rdata, low_addr_data_port_out, high_addr_port_out;
  wire [7:0] low_addr_data_port_in;
  wire xm_done, xm_offchip, xm_busy, aux_ram_enable, low_addr_data_port_oe;
  wire high_addr_port_oe, addr_latch_en, ext_wr_n, ext_rd_n;
  integer fails = 0, compares = 0, seed = 4423, i, n;
  aux_ram_access_decoder aux_ram_access_decoder_inst (.*);
  ext_mem_model ext_mem_model_inst (.clock, .low_out(low_addr_data_port_out),
    .low_oe(low_addr_data_port_oe), .high_out(high_addr_port_out),
    .ale(addr_latch_en), .wr_n(ext_wr_n), .rd_n(ext_rd_n),
    .low_in(low_addr_data_port_in));
  initial forever #4 clock = ~clock;
  // ====================================================
  // Tasks
  task check(input [7:0] seen, input [7:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task sreg(input w, input [7:0] ad, input [7:0] da);
  begin
    @(posedge clock);
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_addr <= ad;
    sfr_wdata <= da;
    if (!w)
      sq.push_back(da);
    @(posedge clock);
    sfr_wr <= 0;
    sfr_rd <= 0;
  end
  endtask
  task xmove(input w, input u, input [15:0] pp, input [7:0] r,
    input [7:0] da, input off);
  begin
    @(posedge clock);
    xm_req <= 1;
    xm_write <= w;
    xm_use_data_pointer <= u;
    data_pointer <= pp;
    indirect_reg <= r;
    xm_wdata <= da;
    xq.push_back({!w, off, da});
    @(posedge clock);
    xm_req <= 0;
    n = 0;
    while (xm_done !== 1'b1 && n < 12)
    begin
      @(posedge clock);
      n = n + 1;
    end
  end
  endtask
  // Watcher takes the oldest note when a result shows
  always @(posedge clock)
  begin
    rd_pend <= sfr_rd;
    if (rd_pend && sq.size() > 0)
      check(sfr_rdata, sq.pop_front());
    if (xm_done === 1'b1 && xq.size() > 0)
    begin
      e = xq.pop_front();
      check(xm_offchip, e[8]);
      if (e[9])
        check(xm_rdata, e[7:0]);
    end
  end
  initial
  begin
    #200000;
    fails = fails + 1;
    print_verdict;
  end
  // ====================================================
  // Sequence
  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 0;
    sreg(0, 8'h9F, 8'h10);
    sreg(0, 8'hA1, 8'h00);
    sreg(1, 8'hA1, 8'hFF);
    sreg(0, 8'hA1, 8'h03);
    sreg(0, 8'h55, 8'h00);
    // Write by pointer, read back by paged indirect
    for (i = 0; i < 8; i = i + 1)
    begin
      a = (i == 0) ? 10'h3FF : $random(seed);
      d = $random(seed);
      xmove(1, 1, {6'h00, a}, 8'h00, d, 0);
      sreg(1, 8'hA1, {6'h00, a[9:8]});
      xmove(0, 0, 16'hFFFF, a[7:0], d, 0);
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      p = (i == 0) ? 16'h0400 : ($random(seed) | 16'h0400);
      xmove(1, 1, p, 8'h00, p[7:0] ^ 8'hA5, 1);
      xmove(0, 1, p, 8'h00, p[7:0] ^ 8'hA5, 1);
    end
    // locked write dropped, unlocked one disables
    sreg(1, 8'h9F, 8'h00);
    sreg(0, 8'h9F, 8'h10);
    @(posedge clock) timed_access_open <= 1;
    sreg(1, 8'h9F, 8'h00);
    @(posedge clock) timed_access_open <= 0;
    sreg(0, 8'h9F, 8'h00);
    xmove(1, 1, {6'h00, a}, 8'h00, ~d, 1);
    xmove(0, 1, {6'h00, a}, 8'h00, ~d, 1);
    xmove(0, 0, 16'h0000, a[7:0], ~d, 1);
    // Second reset re-enables; RAM contents survive
    @(posedge clock) rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    sreg(0, 8'h9F, 8'h10);
    xmove(0, 1, {6'h00, a}, 8'h00, d, 0);
    repeat (3) @(posedge clock);
    check(xq.size(), 8'h00);
    print_verdict;
  end
endmodule // aux_ram_access_decoder_tb_top
bind aux_ram_access_decoder aux_ram_monitor aux_ram_monitor_inst (.*);

// [tb/aux_ram_monitor.sv]
// Purpose: port checks for the aux RAM decoder
// Assumes: one clock, async high reset
// Notes: bound from the bench top
`timescale 1ns/100ps
module aux_ram_monitor (
  input wire clock,
  input wire rst,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire timed_access_open,
  input wire [7:0] sfr_rdata,
  input wire xm_req,
  input wire xm_use_data_pointer,
  input wire [15:0] data_pointer,
  input wire xm_done,
  input wire xm_offchip,
  input wire xm_busy,
  input wire aux_ram_enable,
  input wire low_addr_data_port_oe,
  input wire [7:0] high_addr_port_out,
  input wire high_addr_port_oe,
  input wire addr_latch_en,
  input wire ext_wr_n,
  input wire ext_rd_n
);
  // ====================================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire go = xm_req && !xm_busy;
  wire far = xm_use_data_pointer && data_pointer > 16'h03FF;
  wire hit = aux_ram_enable && !far;
  wire cc_wr = sfr_wr && sfr_addr == 8'h9F;
  wire pins = addr_latch_en || low_addr_data_port_oe || high_addr_port_oe;
  sequence addr_phase;
    xm_busy && xm_offchip && addr_latch_en;
  endsequence
  sequence off_cycle;
    addr_phase ##1 xm_busy[*4] ##1 xm_done;
  endsequence
  en_after_reset_a: assert property (
    $fell(rst) |-> aux_ram_enable) else $error("enable low after reset");
  onchip_done_a: assert property (
    go && hit |=> xm_done && !xm_offchip) else $error("on-chip move late");
  onchip_quiet_a: assert property (
    go && hit |=> !pins && ext_wr_n && ext_rd_n) else $error("pins moved");
  offchip_walk_a: assert property (
    go && far |=> off_cycle) else $error("off-chip cycle wrong");
  high_port_a: assert property (
    go && far |=> high_addr_port_oe &&
    high_addr_port_out == $past(data_pointer[15:8])) else $error("high port");
  disabled_far_a: assert property (
    go && !aux_ram_enable |=> xm_offchip) else $error("disabled not off");
  locked_write_a: assert property (
    cc_wr && !timed_access_open |=> $stable(aux_ram_enable))
    else $error("locked write took");
  enable_bit_a: assert property (
    cc_wr && timed_access_open |=> aux_ram_enable == $past(sfr_wdata[4]))
    else $error("enable bit wrong");
  page_reserved_a: assert property (
    sfr_rd && sfr_addr == 8'hA1 |=> sfr_rdata[7:2] == 6'h00)
    else $error("page reserved bits");
endmodule // aux_ram_monitor

// [tb/ext_mem_model.sv]
// Purpose: off-chip data memory on the multiplexed ports
// Assumes: address taken while addr_latch_en is high
// Notes: a released bus shows the inverse of the last drive
`timescale 1ns/100ps
module ext_mem_model (
  input wire clock,
  input wire [7:0] low_out,
  input wire low_oe,
  input wire [7:0] high_out,
  input wire ale,
  input wire wr_n,
  input wire rd_n,
  output wire [7:0] low_in
);
  // ====================================================
  // Memory
  reg [7:0] mem [0:65535];
  reg [15:0] addr = 16'h0000;
  always @(posedge clock)
  begin
    if (ale)
      addr <= {high_out, low_out};
    if (!wr_n)
      mem[addr] <= low_out;
  end
  assign low_in = low_oe ? low_out : (!rd_n ? mem[addr] : ~low_out);
endmodule // ext_mem_model
